// File: hw/pig_consts.vh
`ifndef PIG_CONSTS_VH
`define PIG_CONSTS_VH

// ==========================================================
// Widths
`define PIG_DATA_W 32
`define PIG_REG_W 16
`define PIG_NDOM 14
`define PIG_SYNC_RST 1'b0

// ==========================================================
// Register indices (byte address = index shifted left by 2)
`define PIG_IDX_W 16
`define PIG_IDX_CTRL 16'h9400
`define PIG_IDX_STAT 16'h9401
`define PIG_IDX_PEND 16'h9404
`define PIG_IDX_SHIFT_W 2

// ==========================================================
// Reset values and masks
`define PIG_CTRL_RST 16'h0000
`define PIG_CTRL_WMASK 16'h3FFF
`define PIG_GATE_RST 1'b0
`define PIG_LO_BYTE_MASK 16'h00FF
`define PIG_HI_BYTE_MASK 16'hFF00
`define PIG_STRB_LO 0
`define PIG_STRB_HI 1

// ==========================================================
// Field positions, shared by control, status and pending words
`define PIG_BIT_TIMER0 0
`define PIG_BIT_TIMER1 1
`define PIG_BIT_SERIAL0 2
`define PIG_BIT_SERIAL1 3
`define PIG_BIT_SERIAL2 4
`define PIG_BIT_GPIO 5
`define PIG_BIT_SIX 6
`define PIG_BIT_I2C 7
`define PIG_BIT_UART 8
`define PIG_BIT_PARPINS 9
`define PIG_BIT_WDOG 10
`define PIG_BIT_OSTICK 11
`define PIG_BIT_EXTMEM 12
`define PIG_BIT_MISC 13

`endif

// File: hw/pig_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "pig_consts.vh"

// ==========================================================
// Two-stage level synchroniser, one lane per bit
module pig_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Data
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= {W{`PIG_SYNC_RST}};
      sync_q <= {W{`PIG_SYNC_RST}};
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule // pig_sync
`default_nettype wire

// File: hw/pig_gate_cell.v
`timescale 1ns/1ps
`default_nettype none
`include "pig_consts.vh"

// ==========================================================
// One peripheral domain: holds its gate request
module pig_gate_cell (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Sleep event
  input wire i_idle_exec,
  input wire i_group_asleep,
  input wire i_ctrl_bit,
  // Domain state
  input wire i_ack_sync,
  output wire o_gate,
  output wire o_pend
);

  reg gate_q;
  reg gate_d;

  // Only the idle instruction moves the gate; a control write alone
  // changes nothing until the next one
  always @* begin
    gate_d = gate_q;
    if (i_idle_exec) begin
      if (i_group_asleep)
        gate_d = i_ctrl_bit;
      else
        gate_d = `PIG_GATE_RST;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      gate_q <= `PIG_GATE_RST;
    else
      gate_q <= gate_d;
  end

  assign o_gate = gate_q;
  // Request and confirmed state disagree while a domain moves
  assign o_pend = gate_q ^ i_ack_sync;

endmodule // pig_gate_cell
`default_nettype wire

// File: hw/pig_top.v
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pig_consts.vh"

// ==========================================================
// Peripheral idle gating with APB register access
// ==========================================================

module pig_top #(
  parameter ADDR_W = 32
) (
  // Clock and reset
  input wire I_CLK,
  input wire I_RST,
  // APB slave
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [ADDR_W-1:0] I_PADDR,
  input wire [`PIG_DATA_W-1:0] I_PWDATA,
  input wire [3:0] I_PSTRB,
  output wire O_PREADY,
  output wire [`PIG_DATA_W-1:0] O_PRDATA,
  output wire O_PSLVERR,
  // CPU sleep controls
  input wire I_IDLE_EXEC,
  input wire I_PERIPH_GROUP_ASLEEP,
  // Confirmations from the gated domains
  input wire [`PIG_NDOM-1:0] I_GATE_ACK,
  // Gate requests, high asks the domain to stop
  output wire O_TIMER0_GATE,
  output wire O_TIMER1_GATE,
  output wire O_SERIAL_PORT0_GATE,
  output wire O_SERIAL_PORT1_GATE,
  output wire O_SERIAL_PORT2_GATE,
  output wire O_GPIO_GATE,
  output wire O_PERIPHERAL_SIX_GATE,
  output wire O_I2C_GATE,
  output wire O_UART_GATE,
  output wire O_PARALLEL_PINS_GATE,
  output wire O_WATCHDOG_GATE,
  output wire O_OS_TICK_TIMER_GATE,
  output wire O_EXT_MEM_GATE,
  output wire O_MISC_GROUP_GATE
);

  // ========================================================
  // Address map
  localparam PAD_W = ADDR_W - `PIG_IDX_W - `PIG_IDX_SHIFT_W;
  localparam [ADDR_W-1:0] ADDR_CTRL =
    {{PAD_W{1'b0}}, `PIG_IDX_CTRL, {`PIG_IDX_SHIFT_W{1'b0}}};
  localparam [ADDR_W-1:0] ADDR_STAT =
    {{PAD_W{1'b0}}, `PIG_IDX_STAT, {`PIG_IDX_SHIFT_W{1'b0}}};
  localparam [ADDR_W-1:0] ADDR_PEND =
    {{PAD_W{1'b0}}, `PIG_IDX_PEND, {`PIG_IDX_SHIFT_W{1'b0}}};
  localparam UPPER_W = `PIG_DATA_W - `PIG_REG_W;
  localparam RSV_W = `PIG_REG_W - `PIG_NDOM;

  // ========================================================
  // Bus state machine, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RESP = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg pready_q;
  reg pready_d;
  reg pslverr_q;
  reg pslverr_d;
  reg [`PIG_DATA_W-1:0] prdata_q;
  reg [`PIG_DATA_W-1:0] prdata_d;

  // ========================================================
  // Registers and per-domain state
  reg [`PIG_REG_W-1:0] ctrl_q;
  reg [`PIG_REG_W-1:0] ctrl_d;
  reg [`PIG_REG_W-1:0] wmask;
  reg [`PIG_REG_W-1:0] rd_word;
  reg rd_hit;
  reg rd_ro;
  wire setup_ph;
  wire access_done;
  wire wr_ctrl;
  wire [`PIG_NDOM-1:0] ack_sync;
  wire [`PIG_NDOM-1:0] gate_q;
  wire [`PIG_NDOM-1:0] pend;
  wire [`PIG_REG_W-1:0] stat_word;
  wire [`PIG_REG_W-1:0] pend_word;
  wire [`PIG_REG_W-1:0] ctrl_word;
  wire hit_ctrl;
  wire hit_stat;
  wire hit_pend;
  wire addr_err;
  wire ro_wr_err;
  wire resp_err;
  wire stat_misc;
  wire stat_extmem;
  wire stat_ostick;
  wire stat_wdog;
  wire stat_parpins;
  wire stat_uart;

  // ========================================================
  // Domain confirmations come from gated clocks: synchronise
  pig_sync #(
    .W(`PIG_NDOM)
  ) u_ack_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d(I_GATE_ACK),
    .o_q(ack_sync)
  );

  // ========================================================
  // One gate cell per domain
  genvar g;
  generate
    for (g = 0; g < `PIG_NDOM; g = g + 1) begin : g_dom
      pig_gate_cell u_cell (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_idle_exec(I_IDLE_EXEC),
        .i_group_asleep(I_PERIPH_GROUP_ASLEEP),
        .i_ctrl_bit(ctrl_q[g]),
        .i_ack_sync(ack_sync[g]),
        .o_gate(gate_q[g]),
        .o_pend(pend[g])
      );
    end
  endgenerate

  // ========================================================
  // Gate outputs, one flip-flop each inside the cells
  assign O_TIMER0_GATE = gate_q[`PIG_BIT_TIMER0];
  assign O_TIMER1_GATE = gate_q[`PIG_BIT_TIMER1];
  assign O_SERIAL_PORT0_GATE = gate_q[`PIG_BIT_SERIAL0];
  assign O_SERIAL_PORT1_GATE = gate_q[`PIG_BIT_SERIAL1];
  assign O_SERIAL_PORT2_GATE = gate_q[`PIG_BIT_SERIAL2];
  assign O_GPIO_GATE = gate_q[`PIG_BIT_GPIO];
  assign O_PERIPHERAL_SIX_GATE = gate_q[`PIG_BIT_SIX];
  assign O_I2C_GATE = gate_q[`PIG_BIT_I2C];
  assign O_UART_GATE = gate_q[`PIG_BIT_UART];
  assign O_PARALLEL_PINS_GATE = gate_q[`PIG_BIT_PARPINS];
  assign O_WATCHDOG_GATE = gate_q[`PIG_BIT_WDOG];
  assign O_OS_TICK_TIMER_GATE = gate_q[`PIG_BIT_OSTICK];
  assign O_EXT_MEM_GATE = gate_q[`PIG_BIT_EXTMEM];
  assign O_MISC_GROUP_GATE = gate_q[`PIG_BIT_MISC];

  // ========================================================
  // Read words
  // Status is the domains' confirmed state, not the request, so
  // software can poll it to see a transition has completed; it lags
  // a domain's own confirmation by the two synchroniser stages
  assign stat_misc = ack_sync[`PIG_BIT_MISC];
  assign stat_extmem = ack_sync[`PIG_BIT_EXTMEM];
  assign stat_ostick = ack_sync[`PIG_BIT_OSTICK];
  assign stat_wdog = ack_sync[`PIG_BIT_WDOG];
  assign stat_parpins = ack_sync[`PIG_BIT_PARPINS];
  assign stat_uart = ack_sync[`PIG_BIT_UART];
  assign stat_word = {
    {RSV_W{1'b0}},
    stat_misc,
    stat_extmem,
    stat_ostick,
    stat_wdog,
    stat_parpins,
    stat_uart,
    ack_sync[`PIG_BIT_I2C:`PIG_BIT_TIMER0]
  };
  // Pending shows domains still moving toward their request
  assign pend_word = {{RSV_W{1'b0}}, pend};
  assign ctrl_word = ctrl_q & `PIG_CTRL_WMASK;

  // ========================================================
  // APB handshake
  assign setup_ph = I_PSEL & ~I_PENABLE;
  assign access_done = I_PSEL & I_PENABLE & pready_q
    & (state_q == ST_RESP);
  assign hit_ctrl = (I_PADDR == ADDR_CTRL);
  assign hit_stat = (I_PADDR == ADDR_STAT);
  assign hit_pend = (I_PADDR == ADDR_PEND);
  assign wr_ctrl = access_done & I_PWRITE & ~pslverr_q
    & hit_ctrl;
  assign addr_err = ~rd_hit;
  assign ro_wr_err = I_PWRITE & rd_ro;
  assign resp_err = addr_err | ro_wr_err;

  // Address decode for the word answered in the access phase
  always @* begin
    rd_word = {`PIG_REG_W{1'b0}};
    rd_hit = 1'b0;
    rd_ro = 1'b0;
    if (hit_ctrl) begin
      rd_word = ctrl_word;
      rd_hit = 1'b1;
    end else if (hit_stat) begin
      rd_word = stat_word;
      rd_hit = 1'b1;
      rd_ro = 1'b1;
    end else if (hit_pend) begin
      rd_word = pend_word;
      rd_hit = 1'b1;
      rd_ro = 1'b1;
    end
  end

  // Answer prepared at the setup edge so outputs stay registered;
  // the price is that a read shows state sampled one cycle early
  always @* begin
    state_d = state_q;
    pready_d = 1'b0;
    pslverr_d = pslverr_q;
    prdata_d = prdata_q;
    case (state_q)
      ST_IDLE: begin
        if (setup_ph) begin
          state_d = ST_RESP;
          pready_d = 1'b1;
          pslverr_d = resp_err;
          if (I_PWRITE | ~rd_hit)
            prdata_d = {`PIG_DATA_W{1'b0}};
          else
            prdata_d = {{UPPER_W{1'b0}}, rd_word};
        end
      end
      ST_RESP: begin
        // Dropping select mid-transfer abandons it with no effect
        if (access_done | ~I_PSEL) begin
          state_d = ST_IDLE;
          pslverr_d = 1'b0;
          prdata_d = {`PIG_DATA_W{1'b0}};
        end else begin
          pready_d = pready_q;
        end
      end
      default: begin
        state_d = ST_IDLE;
        pslverr_d = 1'b0;
        prdata_d = {`PIG_DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= {`PIG_DATA_W{1'b0}};
    end else begin
      state_q <= state_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign O_PREADY = pready_q;
  assign O_PRDATA = prdata_q;
  assign O_PSLVERR = pslverr_q;

  // ========================================================
  // Control register with byte strobes
  // Reserved bits 15:14 never store, so they always read zero
  // Strobes 3..2 and data bits 31..16 reach no register bit
  // A write alone never moves a gate; only the next idle pulse does
  always @* begin
    wmask = {`PIG_REG_W{1'b0}};
    if (I_PSTRB[`PIG_STRB_LO])
      wmask = wmask | `PIG_LO_BYTE_MASK;
    if (I_PSTRB[`PIG_STRB_HI])
      wmask = wmask | `PIG_HI_BYTE_MASK;
    wmask = wmask & `PIG_CTRL_WMASK;
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = (ctrl_q & ~wmask)
        | (I_PWDATA[`PIG_REG_W-1:0] & wmask);
  end

  // Every control bit starts clear, so nothing sleeps after reset
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST)
      ctrl_q <= `PIG_CTRL_RST;
    else
      ctrl_q <= ctrl_d;
  end

endmodule // pig_top
`default_nettype wire

// File: verification/pig_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pig_consts.vh"
// ==========================================================
// Port checks for idle gating
module pig_monitor #(
  parameter ADDR_W = 32
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // APB
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic O_PREADY,
  input wire logic [`PIG_DATA_W-1:0] O_PRDATA,
  input wire logic O_PSLVERR,
  // Sleep
  input wire logic I_IDLE_EXEC,
  input wire logic I_PERIPH_GROUP_ASLEEP,
  input wire logic [`PIG_NDOM-1:0] I_GATE_ACK,
  input wire logic O_TIMER0_GATE,
  input wire logic O_PERIPHERAL_SIX_GATE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  wire logic setup = I_PSEL && !I_PENABLE;
  wire logic stat = I_PADDR == {`PIG_IDX_STAT, 2'b00};
  wire logic [1:0] g = {O_PERIPHERAL_SIX_GATE, O_TIMER0_GATE};
  rdy_after_setup_a: assert property (setup |=> O_PREADY)
    else $error("no ready after setup");
  rdy_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held too long");
  rdata_idle_a: assert property (!O_PREADY |-> O_PRDATA == 0)
    else $error("read data outside access");
  stat_wr_err_a: assert property (
    setup && I_PWRITE && stat |=> O_PSLVERR && O_PREADY)
    else $error("status write not refused");
  stat_ack_a: assert property (
    O_PREADY && !I_PWRITE && stat |->
    O_PRDATA == {18'h0, $past(I_GATE_ACK, 3)})
    else $error("status not synced ack");
  wake_all_a: assert property (
    I_IDLE_EXEC && !I_PERIPH_GROUP_ASLEEP |=> g == 2'b00)
    else $error("gates not woken");
  gate_hold_a: assert property (!I_IDLE_EXEC |=> $stable(g))
    else $error("gate moved without idle");
  err_with_rdy_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  rst_quiet_a: assert property (
    $fell(I_RST) |-> !O_PREADY && g == 2'b00)
    else $error("outputs busy after reset");
  cover property (setup && I_PWRITE);
  cover property (I_IDLE_EXEC && I_PERIPH_GROUP_ASLEEP ##1 O_TIMER0_GATE);
  cover property (O_PSLVERR);
endmodule // pig_monitor

bind pig_top pig_monitor #(.ADDR_W(ADDR_W)) u_mon (.I_CLK, .I_RST,
  .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PREADY, .O_PRDATA,
  .O_PSLVERR, .I_IDLE_EXEC, .I_PERIPH_GROUP_ASLEEP, .I_GATE_ACK,
  .O_TIMER0_GATE, .O_PERIPHERAL_SIX_GATE);
`default_nettype wire

// File: verification/peripheral_idle_gating_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pig_consts.vh"
`define PIG_CHK(a, x) begin num_checks++; if ((a) !== (x)) begin \
  fails++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (x)); end end
// ==========================================================
// Register and gating tests
module peripheral_idle_gating_tb;
  localparam logic [31:0] A_CTRL = {`PIG_IDX_CTRL, 2'b00};
  localparam logic [31:0] A_STAT = {`PIG_IDX_STAT, 2'b00};
  logic clk, rst, psel, penable, pwrite, idle, flag, e;
  logic [31:0] paddr, pwdata, r;
  logic [3:0] pstrb;
  logic [13:0] ack;
  wire logic pready, perr;
  wire logic [31:0] prdata;
  wire logic [13:0] gv;
  int fails, num_checks;
  pig_top dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(perr), .I_IDLE_EXEC(idle),
    .I_PERIPH_GROUP_ASLEEP(flag), .I_GATE_ACK(ack),
    .O_TIMER0_GATE(gv[0]), .O_TIMER1_GATE(gv[1]),
    .O_SERIAL_PORT0_GATE(gv[2]), .O_SERIAL_PORT1_GATE(gv[3]),
    .O_SERIAL_PORT2_GATE(gv[4]), .O_GPIO_GATE(gv[5]),
    .O_PERIPHERAL_SIX_GATE(gv[6]), .O_I2C_GATE(gv[7]),
    .O_UART_GATE(gv[8]), .O_PARALLEL_PINS_GATE(gv[9]),
    .O_WATCHDOG_GATE(gv[10]), .O_OS_TICK_TIMER_GATE(gv[11]),
    .O_EXT_MEM_GATE(gv[12]), .O_MISC_GROUP_GATE(gv[13]));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task test_done;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Request holds until the edge that samples ready; data is taken there
  task apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = perr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [31:0] a, x);
    apb(0, a, 0, 4'h0);
    `PIG_CHK(r, x)
  endtask
  task wr(input logic [31:0] a, d, input logic [3:0] s, input logic x);
    apb(1, a, d, s);
    `PIG_CHK(e, x)
  endtask
  task nap(input logic f);
    @(posedge clk);
    idle <= 1;
    flag <= f;
    @(posedge clk);
    idle <= 0;
    @(negedge clk);
  endtask
  initial begin
    {psel, penable, pwrite, idle, flag} = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 0;
    ack = 0;
    fails = 0;
    num_checks = 0;
    rst = 1;
    repeat (16) @(posedge clk);
    rst <= 0;
    rd(A_CTRL, 0);
    rd(A_STAT, 0);
    $display("reset test done");
    wr(A_CTRL, 32'hFFFF, 4'h1, 0);
    rd(A_CTRL, 32'hFF);
    wr(A_CTRL, 32'hFFFF, 4'hF, 0);
    rd(A_CTRL, 32'h3FFF);
    wr(A_STAT, 32'hFFFF, 4'hF, 1);
    rd(A_STAT, 0);
    wr(A_CTRL + 32'h20, 32'h1, 4'hF, 1);
    $display("register test done");
    wr(A_CTRL, 32'h55, 4'hF, 0);
    `PIG_CHK(gv, 14'h0)
    nap(1);
    `PIG_CHK(gv, 14'h55)
    wr(A_CTRL, 32'h3FAA, 4'hF, 0);
    `PIG_CHK(gv, 14'h55)
    nap(1);
    `PIG_CHK(gv, 14'h3FAA)
    nap(0);
    `PIG_CHK(gv, 14'h0)
    $display("gating test done");
    for (int i = 0; i < 14; i++) begin
      ack <= 14'h1 << i;
      repeat (4) @(posedge clk);
      rd(A_STAT, 32'h1 << i);
    end
    $display("status test done");
    test_done;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    test_done;
  end
endmodule // peripheral_idle_gating_tb
`default_nettype wire
